// [core/pvi_unit.sv]
/*
  Prioritized vectored interrupt unit: level priority resolution, request
  status, pending bits, vectored and fast entry, return sequencing.
  Assumes all inputs are synchronous to clk_sys_in and that the CPU core
  takes push, vector-read and branch strobes in the cycle they stand.
*/
// How it works
// - Bits 7,4,1 order groups; 001 gives B>C>A, 101 gives C>B>A.
// - Priority bit 0 picks which of levels 0 and 1 wins.
// - Bit 5 orders group C; bit 6 orders the 6/7 subgroup.
// - Levels 0-1 form A, 2-4 form B, 5-7 form C.
// - Highest-priority level first; within a level the lower vector wins.
// - Priority setting is undefined after reset; software must write it (the unit loads 00H).
// - Request status bit n shows level n, read only, readable anytime.
// - Reset clears the request status register.
// - Requests still set status bits while globally disabled.
// - Hardware pending bits set on event, request CPU, cleared by unit.
// - Timer A, timer D and PWM overflows use hardware pending bits.
// - Software pending bits clear by writing zero at the source.
// - Service needs global enable, mask bit, top priority, source enable.
// - Accept at instruction end; clear global enable, stack, vector.
// - Return restores PC and flags and sets global enable.
// - Push PC low, PC high, flags; fetch vector high then low.
// - Each vector starts at an even address inside 00H-FFH.
// - Re-enabled globals during service allow nested higher requests.
// - Fast vector pointer is a pair: high at DAH, low at DBH.
// - Mode bits 4-2 pick fast level, bit 1 enables; 6 versus 16.
// - Fast entry copies flags into a hidden shadow register.
// - Any of the eight levels may be the fast level.
// - Mask bit one enables its level; mask sits at DDH.
// - Reset clears fast enable and global enable bits.
// - Fast entry swaps pointer and PC, sets status; return undoes.
`timescale 1ns/1ps
`default_nettype none
module pvi_unit
  import pvi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Register file port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // CPU core
  input wire logic instr_end_in,
  input wire logic global_allow_instr_in,
  input wire logic global_block_instr_in,
  input wire logic return_from_service_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] mem_rdata_in,
  // Interrupt sources
  input wire logic [7:0] sw_pend_in,
  input wire logic [2:0] hw_evt_in,
  input wire logic [2:0] hw_src_en_in,
  // Sequencing towards the CPU core
  output logic irq_request_out,
  output logic acknowledge_strobe_out,
  output logic [2:0] ack_level_out,
  output logic push_en_out,
  output logic [7:0] push_data_out,
  output logic vec_rd_out,
  output logic [7:0] vec_addr_out,
  output logic branch_en_out,
  output logic [15:0] branch_pc_out,
  output logic flags_load_out,
  output logic [7:0] flags_data_out,
  output logic fast_status_out,
  output logic global_enable_out
);

  // ****************************************************************
  // Priority decode
  // ****************************************************************
  function automatic logic [2:0] hw_level(input int idx);
    logic [2:0] lvl;
    lvl = HW_LVL_TMRA;
    if (idx == 1) begin
      lvl = HW_LVL_TMRD;
    end else if (idx == 2) begin
      lvl = HW_LVL_PWM;
    end
    return lvl;
  endfunction

  // Rank: group position in the top two bits, in-group position below
  function automatic logic [3:0] level_rank(input logic [2:0] lvl,
                                            input logic [7:0] prio);
    logic [2:0] code;
    logic [1:0] grp;
    logic [5:0] ord;
    logic [1:0] gpos;
    logic [1:0] ipos;
    logic sub;
    code = {prio[GRP_BIT_HI], prio[GRP_BIT_MID], prio[GRP_BIT_LO]};
    grp = (lvl < 3'd2) ? 2'd0 : ((lvl < 3'd5) ? 2'd1 : 2'd2);
    unique case (code)
      3'b000: ord = 6'b00_01_10;
      3'b001: ord = 6'b01_10_00;
      3'b010: ord = 6'b00_10_01;
      3'b011: ord = 6'b01_00_10;
      3'b100: ord = 6'b10_00_01;
      3'b101: ord = 6'b10_01_00;
      3'b110: ord = 6'b00_10_01;
      3'b111: ord = 6'b01_00_10;
    endcase
    gpos = (ord[5:4] == grp) ? 2'd0 : ((ord[3:2] == grp) ? 2'd1 : 2'd2);
    sub = (lvl == 3'd6) ? prio[C_SUB_BIT] : ~prio[C_SUB_BIT];
    unique case (grp)
      2'd0: ipos = {1'b0, lvl[0] ^ prio[A_ORDER_BIT]};
      2'd1: ipos = 2'(lvl - 3'd2);
      default: begin
        if (lvl == 3'd5) begin
          ipos = prio[C_ORDER_BIT] ? 2'd2 : 2'd0;
        end else begin
          ipos = prio[C_ORDER_BIT] ? {1'b0, sub} : {1'b1, sub};
        end
      end
    endcase
    return {gpos, ipos};
  endfunction

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  pvi_state_t state_q;
  logic [3:0] step_q;
  logic [7:0] prio_q;
  logic [7:0] mask_q;
  logic [7:0] status_q;
  logic [2:0] hw_pend_q;
  logic [15:0] fvp_q;
  logic [2:0] fast_lvl_q;
  logic fast_en_q;
  logic [7:0] shadow_q;
  logic [15:0] pc_q;
  logic [7:0] flags_q;
  logic [7:0] vec_q;
  logic [15:0] target_q;
  logic entry_fast_q;
  logic [2:0] win_lvl;
  logic win_hw;
  logic win_any;
  logic qualify;
  logic accept;
  logic fast_ret;
  logic [7:0] hw_lvl_vec;
  logic [7:0] cand;

  // ****************************************************************
  // Level resolution
  // ****************************************************************
  always_comb begin
    logic [3:0] best;
    logic [3:0] rk;
    best = 4'hF;
    rk = 4'hF;
    win_lvl = 3'h0;
    win_any = 1'b0;
    hw_lvl_vec = 8'h00;
    for (int h = 0; h < 3; h++) begin
      if (hw_pend_q[h]) begin
        hw_lvl_vec[hw_level(h)] = 1'b1;
      end
    end
    cand = status_q & mask_q;
    for (int i = 0; i < 8; i++) begin
      rk = level_rank(3'(i), prio_q);
      if (cand[i] && rk < best) begin
        best = rk;
        win_lvl = 3'(i);
        win_any = 1'b1;
      end
    end
    // Hardware source has the lower vector of a shared level
    win_hw = hw_lvl_vec[win_lvl];
  end

  assign qualify = win_any && global_enable_out;
  assign accept = (state_q == ST_IDLE) && instr_end_in && qualify;
  assign fast_ret = (state_q == ST_IDLE) && return_from_service_in &&
                    fast_status_out;

  // ****************************************************************
  // Register file port
  // ****************************************************************
  // Priority and mask come up zero although software must rewrite them
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prio_q <= PRIO_SET_RST;
      mask_q <= LVL_MASK_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == PRIO_SET_ADDR) begin
        prio_q <= reg_wdata_in;
      end
      if (reg_addr_in == LVL_MASK_ADDR) begin
        mask_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fast_lvl_q <= FLS_RST;
      fast_en_q <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == SYS_MODE_ADDR) begin
      fast_lvl_q <= reg_wdata_in[FLS_LSB +: 3];
      fast_en_q <= reg_wdata_in[FE_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        FVP_HI_ADDR: reg_rdata_out <= fvp_q[15:8];
        FVP_LO_ADDR: reg_rdata_out <= fvp_q[7:0];
        REQ_STAT_ADDR: reg_rdata_out <= status_q;
        LVL_MASK_ADDR: reg_rdata_out <= mask_q;
        SYS_MODE_ADDR: reg_rdata_out <= {3'b000, fast_lvl_q, fast_en_q,
                                         global_enable_out};
        PRIO_SET_ADDR: reg_rdata_out <= prio_q;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Global enable
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      global_enable_out <= 1'b0;
    end else if (accept) begin
      global_enable_out <= 1'b0;
    end else if (global_block_instr_in) begin
      global_enable_out <= 1'b0;
    end else if (global_allow_instr_in) begin
      global_enable_out <= 1'b1;
    end else if (return_from_service_in && state_q == ST_IDLE) begin
      global_enable_out <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == SYS_MODE_ADDR) begin
      global_enable_out <= reg_wdata_in[GE_BIT];
    end
  end

  // ****************************************************************
  // Pending and request status
  // ****************************************************************
  // A new event in the clearing cycle keeps its bit set
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hw_pend_q <= 3'b000;
    end else begin
      for (int h = 0; h < 3; h++) begin
        if (hw_evt_in[h] && hw_src_en_in[h]) begin
          hw_pend_q[h] <= 1'b1;
        end else if (accept && win_hw && win_lvl == hw_level(h)) begin
          hw_pend_q[h] <= 1'b0;
        end
      end
    end
  end

  // Software-cleared bits follow their source, which clears them
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_q <= REQ_STAT_RST;
    end else begin
      status_q <= hw_lvl_vec | sw_pend_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_request_out <= 1'b0;
    end else begin
      irq_request_out <= qualify && (state_q == ST_IDLE);
    end
  end

  // ****************************************************************
  // Entry sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      step_q <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          step_q <= 4'h0;
          if (accept) begin
            state_q <= (fast_en_q && win_lvl == fast_lvl_q) ?
                       ST_FAST : ST_ENTRY;
          end
        end
        ST_ENTRY: begin
          step_q <= step_q + 4'h1;
          if (step_q == ENTRY_LAST - 4'h1) begin
            state_q <= ST_IDLE;
          end
        end
        ST_FAST: begin
          step_q <= step_q + 4'h1;
          if (step_q == FAST_LAST - 4'h1) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Context captured at acceptance
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_q <= 16'h0000;
      flags_q <= 8'h00;
      vec_q <= 8'h00;
      entry_fast_q <= 1'b0;
      acknowledge_strobe_out <= 1'b0;
      ack_level_out <= 3'h0;
    end else begin
      acknowledge_strobe_out <= accept;
      if (accept) begin
        pc_q <= pc_in;
        flags_q <= flags_in;
        // Four bytes per level keeps every vector even below 20H
        vec_q <= {3'b000, win_lvl, ~win_hw, 1'b0};
        entry_fast_q <= fast_en_q && win_lvl == fast_lvl_q;
        ack_level_out <= win_lvl;
      end
    end
  end

  // Stack pushes and vector reads
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      push_en_out <= 1'b0;
      push_data_out <= 8'h00;
      vec_rd_out <= 1'b0;
      vec_addr_out <= 8'h00;
      target_q <= 16'h0000;
    end else begin
      push_en_out <= 1'b0;
      vec_rd_out <= 1'b0;
      if (state_q == ST_ENTRY) begin
        unique case (step_q)
          STEP_PUSH_PCL: begin
            push_en_out <= 1'b1;
            push_data_out <= pc_q[7:0];
          end
          STEP_PUSH_PCH: begin
            push_en_out <= 1'b1;
            push_data_out <= pc_q[15:8];
          end
          STEP_PUSH_FLG: begin
            push_en_out <= 1'b1;
            push_data_out <= flags_q;
          end
          STEP_RD_VHI: begin
            vec_rd_out <= 1'b1;
            vec_addr_out <= vec_q;
          end
          STEP_RD_VLO: begin
            vec_rd_out <= 1'b1;
            vec_addr_out <= vec_q | 8'h01;
          end
          STEP_CAP_VHI: target_q[15:8] <= mem_rdata_in;
          STEP_CAP_VLO: target_q[7:0] <= mem_rdata_in;
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Branch, fast pointer swap and shadow flags
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      branch_en_out <= 1'b0;
      branch_pc_out <= 16'h0000;
      flags_load_out <= 1'b0;
      flags_data_out <= 8'h00;
    end else begin
      branch_en_out <= 1'b0;
      flags_load_out <= 1'b0;
      if (state_q == ST_ENTRY && step_q == ENTRY_LAST - 4'h1) begin
        branch_en_out <= 1'b1;
        branch_pc_out <= target_q;
      end else if (state_q == ST_FAST && step_q == FAST_LAST - 4'h1) begin
        branch_en_out <= 1'b1;
        branch_pc_out <= fvp_q;
      end else if (fast_ret) begin
        branch_en_out <= 1'b1;
        branch_pc_out <= fvp_q;
        flags_load_out <= 1'b1;
        flags_data_out <= shadow_q;
      end
    end
  end

  // Pointer writes lose to the hardware swap in the same cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fvp_q <= FVP_RST;
    end else if (state_q == ST_FAST && step_q == FAST_LAST - 4'h1) begin
      fvp_q <= pc_q;
    end else if (fast_ret) begin
      fvp_q <= pc_in;
    end else if (reg_wr_in && reg_addr_in == FVP_HI_ADDR) begin
      fvp_q[15:8] <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == FVP_LO_ADDR) begin
      fvp_q[7:0] <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow_q <= 8'h00;
      fast_status_out <= 1'b0;
    end else if (accept && fast_en_q && win_lvl == fast_lvl_q) begin
      shadow_q <= flags_in;
    end else if (state_q == ST_FAST && step_q == FAST_LAST - 4'h1) begin
      fast_status_out <= 1'b1;
    end else if (fast_ret) begin
      fast_status_out <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_push_three;
    push_en_out && push_data_out == pc_q[7:0] ##1
    push_en_out && push_data_out == pc_q[15:8] ##1
    push_en_out && push_data_out == flags_q;
  endsequence
  sequence s_vec_reads;
    vec_rd_out && !vec_addr_out[0] ##1 vec_rd_out && vec_addr_out[0];
  endsequence

  property p_ack_clears_ge;
    acknowledge_strobe_out |-> !global_enable_out;
  endproperty
  a_ack_clears_ge: assert property (p_ack_clears_ge)
    else $error("global enable still set after acknowledge");

  property p_ack_qualified;
    acknowledge_strobe_out |-> $past(qualify) && $past(instr_end_in);
  endproperty
  a_ack_qualified: assert property (p_ack_qualified)
    else $error("acknowledge without a qualifying request");

  property p_push_order;
    acknowledge_strobe_out && !entry_fast_q |=> s_push_three;
  endproperty
  a_push_order: assert property (p_push_order)
    else $error("stack push order wrong");

  property p_vec_even;
    acknowledge_strobe_out && !entry_fast_q |-> ##4 s_vec_reads;
  endproperty
  a_vec_even: assert property (p_vec_even)
    else $error("vector read not on even address pair");

  property p_entry_time;
    acknowledge_strobe_out && !entry_fast_q |-> ##15 branch_en_out;
  endproperty
  a_entry_time: assert property (p_entry_time)
    else $error("vectored entry not 16 cycles");

  property p_fast_time;
    acknowledge_strobe_out && entry_fast_q |->
      ##5 (branch_en_out && fast_status_out && !push_en_out);
  endproperty
  a_fast_time: assert property (p_fast_time)
    else $error("fast entry not 6 cycles");

  property p_shadow;
    acknowledge_strobe_out && entry_fast_q |-> shadow_q == $past(flags_in);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow flags not captured");

  property p_fast_return;
    fast_ret |=> branch_en_out && flags_load_out && !fast_status_out &&
                 branch_pc_out == $past(fvp_q) &&
                 fvp_q == $past(pc_in);
  endproperty
  a_fast_return: assert property (p_fast_return)
    else $error("fast return swap wrong");

  property p_return_ge;
    return_from_service_in && state_q == ST_IDLE && !accept &&
      !global_block_instr_in |=> global_enable_out;
  endproperty
  a_return_ge: assert property (p_return_ge)
    else $error("return did not set global enable");

  property p_status_read;
    reg_rd_in && reg_addr_in == REQ_STAT_ADDR |=>
      reg_rdata_out == $past(status_q);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read mismatch");

endmodule
`default_nettype wire

// [core/pvi_pkg.sv]
/*
  Shared constants for the prioritized vectored interrupt unit: register
  offsets, field positions, reset values, cycle counts and the FSM type.
  Assumes an 8-bit register-file port on the CPU clock.
*/
package pvi_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] FVP_HI_ADDR = 8'hDA;
  localparam logic [7:0] FVP_LO_ADDR = 8'hDB;
  localparam logic [7:0] REQ_STAT_ADDR = 8'hDC;
  localparam logic [7:0] LVL_MASK_ADDR = 8'hDD;
  localparam logic [7:0] SYS_MODE_ADDR = 8'hDE;
  localparam logic [7:0] PRIO_SET_ADDR = 8'hFF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int GE_BIT = 0;
  localparam int FE_BIT = 1;
  localparam int FLS_LSB = 2;
  localparam int GRP_BIT_HI = 7;
  localparam int GRP_BIT_MID = 4;
  localparam int GRP_BIT_LO = 1;
  localparam int A_ORDER_BIT = 0;
  localparam int C_ORDER_BIT = 5;
  localparam int C_SUB_BIT = 6;

  // Levels owning the hardware-cleared overflow sources
  localparam logic [2:0] HW_LVL_TMRA = 3'h0;
  localparam logic [2:0] HW_LVL_TMRD = 3'h2;
  localparam logic [2:0] HW_LVL_PWM = 3'h3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] REQ_STAT_RST = 8'h00;
  localparam logic [7:0] LVL_MASK_RST = 8'h00;
  localparam logic [7:0] PRIO_SET_RST = 8'h00;
  localparam logic [15:0] FVP_RST = 16'h0000;
  localparam logic [2:0] FLS_RST = 3'h0;

  // ****************************************************************
  // Timing, in CPU clock cycles from acceptance to branch
  // ****************************************************************
  localparam int ENTRY_CYCLES = 16;
  localparam int FAST_CYCLES = 6;
  localparam logic [3:0] ENTRY_LAST = 4'(ENTRY_CYCLES - 1);
  localparam logic [3:0] FAST_LAST = 4'(FAST_CYCLES - 1);
  localparam logic [3:0] STEP_PUSH_PCL = 4'h0;
  localparam logic [3:0] STEP_PUSH_PCH = 4'h1;
  localparam logic [3:0] STEP_PUSH_FLG = 4'h2;
  localparam logic [3:0] STEP_RD_VHI = 4'h3;
  localparam logic [3:0] STEP_RD_VLO = 4'h4;
  localparam logic [3:0] STEP_CAP_VHI = 4'h5;
  localparam logic [3:0] STEP_CAP_VLO = 4'h6;

  typedef enum {ST_IDLE, ST_ENTRY, ST_FAST} pvi_state_t;
endpackage

// [sim/pvi_cpu_model.sv]
/*
  CPU-side partner: program memory answering vector fetches.
  Assumes fetch strobes on clk_sys_in, data wanted the cycle after.
*/
`timescale 1ns/1ps
`default_nettype none
module pvi_cpu_model (
  // Clock
  input wire logic clk_sys_in,
  // Vector fetch
  input wire logic vec_rd_in,
  input wire logic [7:0] vec_addr_in,
  output logic [7:0] mem_rdata_out
);
  // ****************
  // Program memory
  // ****************
  initial mem_rdata_out = 8'h00;
  // Bus toggles outside a fetch so a stale byte never passes as valid
  always @(posedge clk_sys_in) begin
    if (vec_rd_in) begin
      mem_rdata_out <= vec_addr_in ^ 8'hA5;
    end else begin
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule
`default_nettype wire

// [sim/prioritized_vectored_interrupt_unit_test.sv]
/*
  Self-checking bench for the interrupt unit: registers, priority,
  vectored, hardware-pending and fast entry and return.
  Assumes pvi_unit and the CPU-side memory model.
*/
`timescale 1ns/1ps
`default_nettype none
module prioritized_vectored_interrupt_unit_test
  import pvi_pkg::*;
;
  // ****************
  // Stimulus and design
  // ****************
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, instr_end_in = 1'b0;
  logic global_allow_instr_in = 1'b0, global_block_instr_in = 1'b0;
  logic return_from_service_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic [7:0] flags_in = 8'h5A, sw_pend_in = 8'h00, mem_rdata;
  logic [15:0] pc_in = 16'hABCD, branch_pc_out, br;
  logic [2:0] hw_evt_in = 3'h0, hw_src_en_in = 3'h7, ack_level_out;
  logic [7:0] reg_rdata_out, push_data_out, vec_addr_out, flags_data_out, fl;
  logic irq_request_out, acknowledge_strobe_out, push_en_out, vec_rd_out;
  logic branch_en_out, flags_load_out, fast_status_out, global_enable_out;
  logic [7:0] pushes [$];
  logic [7:0] vecs [$];
  int cyc = 0, ack_cyc = 0, br_cyc = 0, err_count = 0, tests_run = 0;
  logic [2:0] hwl [3] = '{HW_LVL_TMRA, HW_LVL_TMRD, HW_LVL_PWM};
  // Pending, mask, priority setting, winning level
  logic [31:0] tbl [9] = '{32'h27FF_0000, 32'h27FF_0101, 32'h27FF_0202,
    32'h27FF_8205, 32'h27FE_0001, 32'hE0FF_8005, 32'hE0FF_A006,
    32'hE0FF_E007, 32'h1CFF_0202};

  always #12.5 clk_sys_in = ~clk_sys_in;

  pvi_unit pvi_unit_i (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .instr_end_in,
    .global_allow_instr_in, .global_block_instr_in, .return_from_service_in,
    .pc_in, .flags_in, .mem_rdata_in(mem_rdata), .sw_pend_in, .hw_evt_in,
    .hw_src_en_in, .irq_request_out, .acknowledge_strobe_out,
    .ack_level_out, .push_en_out, .push_data_out, .vec_rd_out, .vec_addr_out,
    .branch_en_out, .branch_pc_out, .flags_load_out, .flags_data_out,
    .fast_status_out, .global_enable_out);

  pvi_cpu_model pvi_cpu_model_i (.clk_sys_in, .vec_rd_in(vec_rd_out),
    .vec_addr_in(vec_addr_out), .mem_rdata_out(mem_rdata));

  // ****************
  // Monitor, timeout and tasks
  // ****************
  always @(posedge clk_sys_in) begin
    cyc++;
    if (push_en_out) pushes.push_back(push_data_out);
    if (vec_rd_out) vecs.push_back(vec_addr_out);
    if (acknowledge_strobe_out) ack_cyc = cyc;
    if (branch_en_out) begin
      br = branch_pc_out;
      br_cyc = cyc;
    end
    if (flags_load_out) fl = flags_data_out;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [23:0] e, logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk_sys_in) #1;
    s = 1'b1;
    @(posedge clk_sys_in) #1;
    s = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    pulse(reg_wr_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, string n);
    reg_addr_in = a;
    pulse(reg_rd_in);
    chk(n, 24'(e), 24'(reg_rdata_out));
  endtask

  task automatic serve(input logic [2:0] lv, logic [7:0] va, bit fast);
    logic [15:0] eb = fast ? 16'h1234 : {va ^ 8'hA5, (va + 8'h01) ^ 8'hA5};
    pushes.delete();
    vecs.delete();
    pulse(instr_end_in);
    repeat (18) @(posedge clk_sys_in);
    #1;
    chk("level", 24'(lv), 24'(ack_level_out));
    chk("ge off", 24'h00_0000, 24'(global_enable_out));
    chk("latency", 24'(fast ? 5 : 15), 24'(br_cyc - ack_cyc));
    chk("npush", 24'(fast ? 0 : 3), 24'(pushes.size()));
    chk("branch", 24'(eb), 24'(br));
    if (!fast) begin
      chk("push", {pc_in[7:0], pc_in[15:8], flags_in},
        {pushes[0], pushes[1], pushes[2]});
      chk("vec", 24'({va, va + 8'h01}), 24'({vecs[0], vecs[1]}));
    end
  endtask

  task automatic ret();
    pulse(return_from_service_in);
    @(posedge clk_sys_in) #1;
    chk("ge on", 24'h00_0001, 24'(global_enable_out));
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (12) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    rd(REQ_STAT_ADDR, 8'h00, "status rst");
    chk("ge rst", 24'h00_0000, 24'(global_enable_out));
    chk("fast rst", 24'h00_0000, 24'(fast_status_out));
    wr(FVP_HI_ADDR, 8'h12);
    wr(FVP_LO_ADDR, 8'h34);
    rd(FVP_HI_ADDR, 8'h12, "ptr hi");
    rd(FVP_LO_ADDR, 8'h34, "ptr lo");
    wr(REQ_STAT_ADDR, 8'hFF);
    rd(REQ_STAT_ADDR, 8'h00, "status ro");
    rd(8'h10, 8'h00, "unmapped");
    sw_pend_in = 8'h25;
    wr(LVL_MASK_ADDR, 8'hFF);
    rd(LVL_MASK_ADDR, 8'hFF, "mask");
    rd(REQ_STAT_ADDR, 8'h25, "status polled");
    chk("no req", 24'h00_0000, 24'(irq_request_out));
    $display("test registers done");
    foreach (tbl[i]) begin
      sw_pend_in = tbl[i][31:24];
      wr(LVL_MASK_ADDR, tbl[i][23:16]);
      wr(PRIO_SET_ADDR, tbl[i][15:8]);
      pulse(global_allow_instr_in);
      @(posedge clk_sys_in) #1;
      chk("req", 24'h00_0001, 24'(irq_request_out));
      serve(tbl[i][2:0], {3'b000, tbl[i][2:0], 2'b10}, 1'b0);
      sw_pend_in = 8'h00;
      ret();
    end
    $display("test priority done");
    wr(PRIO_SET_ADDR, 8'h00);
    hw_src_en_in = 3'h0;
    hw_evt_in = 3'h7;
    @(posedge clk_sys_in) #1;
    hw_evt_in = 3'h0;
    hw_src_en_in = 3'h7;
    rd(REQ_STAT_ADDR, 8'h00, "source off");
    foreach (hwl[i]) begin
      @(posedge clk_sys_in) #1;
      hw_evt_in[i] = 1'b1;
      @(posedge clk_sys_in) #1;
      hw_evt_in = 3'h0;
      rd(REQ_STAT_ADDR, 8'h01 << hwl[i], "hw pend");
      serve(hwl[i], {3'b000, hwl[i], 2'b00}, 1'b0);
      rd(REQ_STAT_ADDR, 8'h00, "hw clear");
      ret();
    end
    $display("test hardware pending done");
    wr(SYS_MODE_ADDR, 8'h17);
    sw_pend_in = 8'h20;
    serve(3'h5, 8'h00, 1'b1);
    chk("fast set", 24'h00_0001, 24'(fast_status_out));
    sw_pend_in = 8'h00;
    pc_in = 16'h4321;
    flags_in = 8'h00;
    ret();
    chk("fast back", 24'h00_ABCD, 24'(br));
    chk("shadow", 24'h00_005A, 24'(fl));
    chk("fast clr", 24'h00_0000, 24'(fast_status_out));
    rd(FVP_HI_ADDR, 8'h43, "ptr swap");
    $display("test fast entry done");
    print_verdict();
  end
endmodule
`default_nettype wire
